// [design/agc_pkg.sv]
// constants shared by the gain step controller
package agc_pkg;
  // level and gain units are half-dB steps, signed
  localparam int LVL_W = 8;
  localparam int TMR_W = 24;
  localparam int RATIO_W = 2;
  // pivot of the compression curve: 10 dBV in half-dB units
  localparam logic signed [7:0] PIVOT_LVL = 8'sh14;
  // reset value of the gain register (half-dB units)
  localparam logic signed [7:0] GAIN_RST = 8'sh00;
  // timer reset value
  localparam logic [23:0] TMR_RST = 24'h000000;
  // compression ratio codes: 1:1, 2:1, 4:1, 8:1 (shift amount)
  typedef enum logic [1:0] {
    RATIO_1, RATIO_2, RATIO_4, RATIO_8
  } ratio_t;
  // kind of the previous gain change
  typedef enum logic [1:0] {
    CHG_NONE, CHG_DOWN, CHG_UP
  } chg_t;
endpackage

// [design/agc_gain_step_controller.sv]
// automatic gain step sequencer for a programmable gain stage
`timescale 1ns/100ps
`default_nettype none
module agc_gain_step_controller #(
  parameter int LVL_W = agc_pkg::LVL_W,
  parameter int TMR_W = agc_pkg::TMR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic agcEnable,
  input wire logic shutdown,
  input wire logic holdEnable,
  input wire logic signed [LVL_W-1:0] envLevel,
  input wire logic signed [LVL_W-1:0] limiterLevel,
  input wire logic [1:0] ratio,
  input wire logic signed [LVL_W-1:0] noiseGate,
  input wire logic signed [LVL_W-1:0] maxGain,
  input wire logic signed [LVL_W-1:0] fixedGain,
  input wire logic [TMR_W-1:0] attackCycles,
  input wire logic [TMR_W-1:0] releaseCycles,
  input wire logic [TMR_W-1:0] holdCycles,
  output logic signed [LVL_W-1:0] gain,
  output logic gainUp,
  output logic gainDown
);

  ////////////////////////////////////////////////////////////////////////
  // saturating clamp of a wide value to the level width
  function automatic logic signed [LVL_W-1:0] clampLvl(
    input logic signed [LVL_W+3:0] v
  );
    logic signed [LVL_W+3:0] hi;
    logic signed [LVL_W+3:0] lo;
    hi = (LVL_W+4)'((1 <<< (LVL_W-1)) - 1);
    lo = -hi - (LVL_W+4)'(1);
    if (v > hi) begin
      return hi[LVL_W-1:0];
    end else if (v < lo) begin
      return lo[LVL_W-1:0];
    end
    return v[LVL_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  logic signed [LVL_W-1:0] gain_q, gain_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  agc_pkg::chg_t last_q, last_d;
  logic up_q, up_d;
  logic down_q, down_d;
  logic active_q, active_d;

  // extended copies for arithmetic
  logic signed [LVL_W+3:0] envX, limX, fixX, maxX, pivX, drop, target;
  logic signed [LVL_W+3:0] outLvl;
  logic signed [LVL_W-1:0] targetGain;
  logic attackDone, releaseDone, gateOpen, wantDown, wantUp;
  logic [TMR_W-1:0] upWait;

  ////////////////////////////////////////////////////////////////////////
  // desired gain from the compression curve and the limiter
  always_comb begin
    envX = (LVL_W+4)'(envLevel);
    limX = (LVL_W+4)'(limiterLevel);
    fixX = (LVL_W+4)'(fixedGain);
    maxX = (LVL_W+4)'(maxGain);
    pivX = (LVL_W+4)'(agc_pkg::PIVOT_LVL);
    // level below the pivot; compression adds (1-1/r) of it
    drop = pivX - envX;
    if (drop < 0) begin
      drop = '0;
    end
    target = fixX + drop - (drop >>> ratio);
    // cap at maximum gain
    if (target > maxX) begin
      target = maxX;
    end
    // limiter takes precedence: output may not exceed limiter level
    outLvl = envX + target;
    if (outLvl > limX) begin
      target = limX - envX;
    end
    targetGain = clampLvl(target);
  end

  ////////////////////////////////////////////////////////////////////////
  // step permission
  always_comb begin
    gateOpen = (envLevel > noiseGate);
    attackDone = (tmr_q >= attackCycles);
    // hold replaces release only right after a decrement
    if (holdEnable && last_q == agc_pkg::CHG_DOWN &&
        holdCycles > releaseCycles) begin
      upWait = holdCycles;
    end else begin
      upWait = releaseCycles;
    end
    releaseDone = (tmr_q >= upWait);
    wantDown = (envX + (LVL_W+4)'(gain_q) > limX) ||
               (targetGain < gain_q);
    wantUp = (targetGain > gain_q) && (gain_q < maxGain);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: one half-dB step per permitted edge
  always_comb begin
    gain_d = gain_q;
    tmr_d = tmr_q;
    last_d = last_q;
    up_d = 1'b0;
    down_d = 1'b0;
    active_d = agcEnable && !shutdown;
    if (!active_d || !active_q) begin
      // disabled, shut down or just re-enabled: fixed gain
      gain_d = fixedGain;
      tmr_d = agc_pkg::TMR_RST;
      last_d = agc_pkg::CHG_NONE;
    end else begin
      if (tmr_q != '1) begin
        tmr_d = tmr_q + TMR_W'(1);
      end
      if (gateOpen) begin
        if (wantDown && attackDone) begin
          gain_d = gain_q - LVL_W'(1);
          down_d = 1'b1;
          last_d = agc_pkg::CHG_DOWN;
          tmr_d = agc_pkg::TMR_RST;
        end else if (!wantDown && wantUp && releaseDone) begin
          gain_d = gain_q + LVL_W'(1);
          up_d = 1'b1;
          last_d = agc_pkg::CHG_UP;
          tmr_d = agc_pkg::TMR_RST;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gain_q <= agc_pkg::GAIN_RST;
      tmr_q <= agc_pkg::TMR_RST;
      last_q <= agc_pkg::CHG_NONE;
      up_q <= 1'b0;
      down_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      gain_q <= gain_d;
      tmr_q <= tmr_d;
      last_q <= last_d;
      up_q <= up_d;
      down_q <= down_d;
      active_q <= active_d;
    end
  end

  assign gain = gain_q;
  assign gainUp = up_q;
  assign gainDown = down_q;

endmodule // agc_gain_step_controller
`default_nettype wire

// [verif/agc_env_model.sv]
// envelope detector model feeding the controller
`timescale 1ns/100ps
`default_nettype none
module agc_env_model (
  input wire logic ref_clk,
  input wire logic signed [7:0] tgt,
  output logic signed [7:0] envLevel
);
  // detector settles one edge after the level changes
  always_ff @(posedge ref_clk) envLevel <= tgt;
endmodule // agc_env_model
`default_nettype wire

// [verif/agc_gain_step_controller_props.sv]
// port checker for the gain step controller
`timescale 1ns/100ps
`default_nettype none
module agc_gain_step_controller_props (
  input wire logic ref_clk, rst, agcEnable, shutdown, holdEnable, gainUp,
  input wire logic gainDown,
  input wire logic signed [7:0] envLevel, noiseGate, maxGain, fixedGain, gain,
  input wire logic [23:0] attackCycles, releaseCycles, holdCycles
);
  logic [23:0] gap_q, gap_d;
  logic dn_q, dn_d;
  // edges since the last step, and whether it was a decrement
  always_comb begin
    gap_d = gainUp || gainDown ? 24'h0 : gap_q + 24'(~&gap_q);
    dn_d = (dn_q || gainDown) && !gainUp && agcEnable && !shutdown;
  end
  always_ff @(posedge ref_clk or posedge rst)
    {gap_q, dn_q} <= rst ? 25'h1FFFFFE : {gap_d, dn_d};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_up; gainUp |-> gain == $past(gain) + 1; endproperty
  a_up: assert property (p_up) else $error("up");
  property p_dn; gainDown |-> gain == $past(gain) - 1; endproperty
  a_dn: assert property (p_dn) else $error("dn");
  property p_max; gainUp |-> gain <= maxGain; endproperty
  a_max: assert property (p_max) else $error("max");
  property p_gate; gainUp || gainDown |-> $past(envLevel) > $past(noiseGate)
    || $past(envLevel, 2) > $past(noiseGate, 2); endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_atk; gainDown |-> gap_q >= attackCycles; endproperty
  a_atk: assert property (p_atk) else $error("atk");
  property p_rel; gainUp |-> gap_q >= releaseCycles; endproperty
  a_rel: assert property (p_rel) else $error("rel");
  // hold setting as it stood at the edge that decided the step
  property p_hold; gainUp && dn_q && $past(holdEnable) &&
    $past(holdCycles) > $past(releaseCycles)
    |-> gap_q >= holdCycles; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_fix; ((!agcEnable || shutdown) && $stable(fixedGain)) [*2]
    |-> gain == fixedGain; endproperty
  a_fix: assert property (p_fix) else $error("fixed");
  c_up: cover property (gainUp);
  c_dn: cover property (gainDown);
  c_hold: cover property (gainUp && dn_q);
endmodule // agc_gain_step_controller_props
bind agc_gain_step_controller agc_gain_step_controller_props
  agc_gain_step_controller_props_inst (.*);
`default_nettype wire

// [verif/tb_agc_gain_step_controller.sv]
// bench for the gain step controller
`timescale 1ns/100ps
`default_nettype none
module tb_agc_gain_step_controller;
  logic ref_clk = 0, rst = 1, agcEnable = 1, shutdown = 0, holdEnable = 1;
  logic gainUp, gainDown;
  logic [1:0] ratio = 0;
  logic signed [7:0] tgt = 0, envLevel, gain, noiseGate = 8'shD8;
  logic signed [7:0] fixedGain = 8'sh04, prevGain = 0;
  logic [31:0] lfsr = 32'hA540A19D;
  int errors = 0, samplesChecked = 0;
  always #5 ref_clk = ~ref_clk;
  agc_env_model agc_env_model_inst (.ref_clk, .tgt, .envLevel);
  // limiter 15 dB, cap 15 dB, attack far shorter than release and hold
  agc_gain_step_controller agc_gain_step_controller_inst (.ref_clk, .rst,
    .agcEnable, .shutdown, .holdEnable, .envLevel, .limiterLevel(8'sh1E),
    .ratio, .noiseGate, .maxGain(8'sh1E), .fixedGain, .gain, .gainUp,
    .attackCycles(24'h1), .releaseCycles(24'h64), .holdCycles(24'hC8),
    .gainDown);
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  // steady gain: compressed about the pivot, capped, then limited
  function automatic logic signed [7:0] expGain(logic signed [7:0] e);
    logic signed [9:0] d, t;
    d = e < 8'sh14 ? 10'sh14 - e : 10'sh0;
    t = fixedGain + d - (d >>> ratio);
    t = t > 10'sh1E ? 10'sh1E : t;
    return e + t > 10'sh1E ? 8'sh1E - e : t[7:0];
  endfunction
  task automatic chk(logic signed [7:0] x);
    samplesChecked++;
    if (gain !== x) begin
      $display("CHECK FAILED %0t %h %h", $time, gain, x);
      errors++;
    end
  endtask
  // every step pulse must move the settled gain by exactly one unit
  always @(negedge ref_clk) begin
    if (gainUp || gainDown) begin
      samplesChecked++;
      if (gain !== prevGain + (gainUp ? 8'sh01 : 8'shFF)) begin
        $display("CHECK FAILED %0t %h %h", $time, gain, prevGain);
        errors++;
      end
    end
    prevGain = gain;
  end
  task automatic settle(logic signed [7:0] e, logic [1:0] r);
    tgt = e;
    ratio = r;
    for (int i = 0; i < 6000 && gain !== expGain(e); i++) #10;
    chk(expGain(e));
    if (gain !== expGain(e)) end_sim;
  endtask
  // ratios, cap, limiter, random levels, gate, shutdown reload
  initial begin
    #116 rst = 0;
    #10 chk(8'sh04);
    for (int r = 0; r < 4; r++) settle(8'sh04, 2'(r));
    settle(8'shEC, 2'h3);
    settle(8'sh2B, 2'h1);
    repeat (6) begin
      lfsr = nxt(lfsr);
      holdEnable = lfsr[0];
      settle(8'(lfsr[7:2]) - 8'sh14, lfsr[9:8]);
    end
    settle(8'sh14, 2'h3);
    noiseGate = 8'sh7F;
    tgt = 8'shEC;
    #3000 chk(8'sh04);
    shutdown = 1;
    fixedGain = 8'sh06;
    #20 chk(8'sh06);
    end_sim;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule // tb_agc_gain_step_controller
`default_nettype wire
